/* File: verilog/rss_pkg.sv */
// Package: constants for the run/stop sequence and source select block
package rss_pkg;
  // Source-select parameter codes (bit0: sequence, bit1: reference)
  localparam logic [1:0] SRC_SEL_KEYPAD_BOTH  = 2'h0;
  localparam logic [1:0] SRC_SEL_SEQ_TERM     = 2'h1;
  localparam logic [1:0] SRC_SEL_REF_TERM     = 2'h2;
  localparam logic [1:0] SRC_SEL_FACTORY      = 2'h3;
  localparam int         SRC_SEL_SEQ_BIT      = 0;
  localparam int         SRC_SEL_REF_BIT      = 1;
  // Debounce time and its cycle count at 100 MHz
  localparam int         CLK_FREQ_HZ          = 100_000_000;
  localparam int         DEBOUNCE_US          = 10;
  localparam int         DEBOUNCE_CYC         =
    (DEBOUNCE_US * (CLK_FREQ_HZ / 1_000_000));
  // Direction encoding
  localparam logic       DIR_FWD              = 1'h0;
  localparam logic       DIR_REV              = 1'h1;
  // Control state
  typedef enum logic [2:0]
  {
    ST_STOP  = 3'h1,
    ST_RUN   = 3'h2,
    ST_FAULT = 3'h4
  } rss_state_t;
endpackage

/* File: verilog/rss_debounce.sv */
// Module: contact synchroniser and debouncer
`timescale 1ns/1ns
`default_nettype none
module rss_debounce #(
  parameter int CNT_MAX = 1000
) (
  input  wire logic i_clk,     // System clock
  input  wire logic i_rst_n,   // Synchronous-released reset
  input  wire logic i_raw,     // Raw contact level, 1 = closed
  output logic      o_clean    // Stable contact level
);
  localparam int CW = $clog2(CNT_MAX + 1);
  logic          s1_r;
  logic          s2_r;
  logic [CW-1:0] cnt_r;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s1_r <= 1'h0;
      s2_r <= 1'h0;
    end
    else
    begin
      s1_r <= i_raw;
      s2_r <= s1_r;
    end
  end

  // Accept a new level only after it has held steady
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_r   <= '0;
      o_clean <= 1'h0;
    end
    else if (s2_r == o_clean)
      cnt_r <= '0;
    else if (cnt_r == CW'(CNT_MAX - 1))
    begin
      cnt_r   <= '0;
      o_clean <= s2_r;
    end
    else
      cnt_r <= cnt_r + CW'(1);
  end
endmodule
`default_nettype wire

/* File: verilog/rss_top.sv */
// Module: run/stop sequencing and speed reference source select
// Functional notes
// - With the keypad as sequence source, run key starts, stop key stops, direction key toggles direction.
// - With terminals as sequence source, commands come from the terminals in two-wire or three-wire form.
// - Sequence inputs are contact closures and a closed contact reads as active.
// - Two-wire mode runs only while a forward or reverse contact is held, direction from which one.
// - Two-wire mode resumes running at power return if a run contact is still closed.
// - Three-wire mode latches run on a run closure only while the stop contact is closed.
// - Three-wire mode clears the run latch on any opening of the stop contact.
// - Three-wire mode clears the run latch at once on power loss.
// - Three-wire mode takes direction from a maintained contact, closed meaning reverse.
// - With local reference the keypad speed value is the frequency reference.
// - Analog reference maps the digitized input linearly from zero to full speed.
// - Reference lamp is off for keypad reference and on for terminal reference.
// - Sequence lamp is off for keypad sequence and on for terminal sequence.
// - Factory reset sets both sources to the terminals, code 3.
// - Two-wire mode with both run contacts closed stops and flags an external fault.
`timescale 1ns/1ns
`default_nettype none
module rss_top #(
  parameter int REF_W        = 12,
  parameter int DEBOUNCE_CYC = rss_pkg::DEBOUNCE_CYC
) (
  input  wire logic             I_SYS_CLK,        // System clock
  input  wire logic             I_ARST_N,         // Async reset, power loss
  input  wire logic             I_FACTORY_RESET,  // Restore default sources
  input  wire logic             I_SRC_SEL_WE,     // Write source select
  input  wire logic [1:0]       I_SRC_SEL,        // Source select code
  input  wire logic             I_THREE_WIRE,     // 1 = three-wire control
  input  wire logic             I_KEY_RUN,        // Run key pulse
  input  wire logic             I_KEY_STOP,       // Stop key pulse
  input  wire logic             I_DIRECTION_KEY,  // Direction key pulse
  input  wire logic             I_TERM_FWD_RUN,   // Fwd run / 3W run contact
  input  wire logic             I_TERM_REV_RUN,   // Rev run / 3W stop contact
  input  wire logic             I_TERM_DIR,       // 3W direction contact
  input  wire logic [REF_W-1:0] I_KEYPAD_REF,     // Keypad speed value
  input  wire logic [REF_W-1:0] I_ANALOG_REF,     // Digitized analog ref
  output logic                  O_RUN,            // Motor run command
  output logic                  O_DIR,            // 1 = reverse
  output logic                  O_EXT_FAULT,      // External fault flag
  output logic [REF_W-1:0]      O_FREQ_REF,       // Frequency reference
  output logic [1:0]            O_SRC_SEL,        // Current source select
  output logic                  O_SEQ_SOURCE_LAMP,// Sequence source lamp
  output logic                  O_REF_SOURCE_LAMP // Reference source lamp
);
  // ------------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------------
  logic rst_s1_r;
  logic rst_n;
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      rst_s1_r <= 1'h0;
      rst_n    <= 1'h0;
    end
    else
    begin
      rst_s1_r <= 1'h1;
      rst_n    <= rst_s1_r;
    end
  end

  // ------------------------------------------------------------------
  // Contact conditioning
  // ------------------------------------------------------------------
  logic [2:0] raw_c;
  logic [2:0] clean_c;
  assign raw_c = {I_TERM_DIR, I_TERM_REV_RUN, I_TERM_FWD_RUN};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_deb
      rss_debounce #(
        .CNT_MAX (DEBOUNCE_CYC)
      ) u_deb (
        .i_clk   (I_SYS_CLK),
        .i_rst_n (rst_n),
        .i_raw   (raw_c[gi]),
        .o_clean (clean_c[gi])
      );
    end
  endgenerate
  logic c_fwd;
  logic c_rev;
  logic c_dir;
  assign c_fwd = clean_c[0];
  assign c_rev = clean_c[1];
  assign c_dir = clean_c[2];
  logic c_fwd_d_r;
  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      c_fwd_d_r <= 1'h0;
    else
      c_fwd_d_r <= c_fwd;
  end

  // ------------------------------------------------------------------
  // Source select
  // ------------------------------------------------------------------
  logic [1:0] src_r;
  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      src_r <= rss_pkg::SRC_SEL_FACTORY;
    else if (I_FACTORY_RESET)
      src_r <= rss_pkg::SRC_SEL_FACTORY;
    else if (I_SRC_SEL_WE)
      src_r <= I_SRC_SEL;
  end
  logic seq_term;
  logic ref_term;
  assign seq_term = src_r[rss_pkg::SRC_SEL_SEQ_BIT];
  assign ref_term = src_r[rss_pkg::SRC_SEL_REF_BIT];

  // ------------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------------
  rss_pkg::rss_state_t state_r;
  rss_pkg::rss_state_t state_nxt;
  logic                fault_nxt;
  always_comb
  begin
    state_nxt = state_r;
    fault_nxt = 1'h0;
    if (!seq_term)
    begin
      if (I_KEY_STOP)
        state_nxt = rss_pkg::ST_STOP;
      else if (I_KEY_RUN)
        state_nxt = rss_pkg::ST_RUN;
      else if (state_r == rss_pkg::ST_FAULT)
        state_nxt = rss_pkg::ST_STOP;
    end
    else if (!I_THREE_WIRE)
    begin
      // Level driven; also resumes at power return
      if (c_fwd && c_rev)
      begin
        state_nxt = rss_pkg::ST_FAULT;
        fault_nxt = 1'h1;
      end
      else if (c_fwd || c_rev)
        state_nxt = rss_pkg::ST_RUN;
      else
        state_nxt = rss_pkg::ST_STOP;
    end
    else
    begin
      if (!c_rev)
        state_nxt = rss_pkg::ST_STOP;
      else if (c_fwd && !c_fwd_d_r)
        state_nxt = rss_pkg::ST_RUN;
      else if (state_r == rss_pkg::ST_FAULT)
        state_nxt = rss_pkg::ST_STOP;
    end
  end
  // Reset clears the latch; a run contact still closed at power return latches run again once debounced
  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= rss_pkg::ST_STOP;
    else
      state_r <= state_nxt;
  end
  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      O_RUN       <= 1'h0;
      O_EXT_FAULT <= 1'h0;
    end
    else
    begin
      O_RUN       <= (state_nxt == rss_pkg::ST_RUN);
      O_EXT_FAULT <= fault_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Direction
  // ------------------------------------------------------------------
  logic key_dir_r;
  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      key_dir_r <= rss_pkg::DIR_FWD;
    else if (!seq_term && I_DIRECTION_KEY)
      key_dir_r <= ~key_dir_r;
  end
  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      O_DIR <= rss_pkg::DIR_FWD;
    else if (!seq_term)
      O_DIR <= (I_DIRECTION_KEY ? ~key_dir_r : key_dir_r);
    else if (I_THREE_WIRE)
      O_DIR <= c_dir ? rss_pkg::DIR_REV : rss_pkg::DIR_FWD;
    else if (c_rev && !c_fwd)
      O_DIR <= rss_pkg::DIR_REV;
    else if (c_fwd && !c_rev)
      O_DIR <= rss_pkg::DIR_FWD;
  end

  // ------------------------------------------------------------------
  // Reference and lamps
  // ------------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      O_FREQ_REF        <= '0;
      O_SRC_SEL         <= rss_pkg::SRC_SEL_FACTORY;
      // Lamps agree with the default source while held in reset
      O_SEQ_SOURCE_LAMP <=
        rss_pkg::SRC_SEL_FACTORY[rss_pkg::SRC_SEL_SEQ_BIT];
      O_REF_SOURCE_LAMP <=
        rss_pkg::SRC_SEL_FACTORY[rss_pkg::SRC_SEL_REF_BIT];
    end
    else
    begin
      // Analog code passes straight: 0 = zero, full scale = full speed
      O_FREQ_REF        <= ref_term ? I_ANALOG_REF
                                    : I_KEYPAD_REF;
      O_SRC_SEL         <= src_r;
      O_SEQ_SOURCE_LAMP <= seq_term;
      O_REF_SOURCE_LAMP <= ref_term;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/rss_top_properties.sv */
// Checker: port-level properties of the run/stop source select block
`timescale 1ns/1ns
`default_nettype none
module rss_top_properties #(
  parameter int REF_W        = 12,
  parameter int DEBOUNCE_CYC = rss_pkg::DEBOUNCE_CYC
) (
  input wire logic             I_SYS_CLK,
  input wire logic             I_ARST_N,
  input wire logic             I_FACTORY_RESET,
  input wire logic             I_SRC_SEL_WE,
  input wire logic             I_THREE_WIRE,
  input wire logic             I_KEY_RUN,
  input wire logic             I_KEY_STOP,
  input wire logic             I_TERM_FWD_RUN,
  input wire logic             I_TERM_REV_RUN,
  input wire logic [REF_W-1:0] I_KEYPAD_REF,
  input wire logic [REF_W-1:0] I_ANALOG_REF,
  input wire logic             O_RUN,
  input wire logic             O_EXT_FAULT,
  input wire logic [REF_W-1:0] O_FREQ_REF,
  input wire logic [1:0]       O_SRC_SEL,
  input wire logic             O_SEQ_SOURCE_LAMP,
  input wire logic             O_REF_SOURCE_LAMP
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_ARST_N);
  // Cycles each terminal condition has held unbroken
  logic [2:0] c;
  int         n [3];
  assign c[2] = O_SRC_SEL[0] && !I_THREE_WIRE
                && I_TERM_FWD_RUN && I_TERM_REV_RUN;
  assign c[1] = O_SRC_SEL[0] && I_THREE_WIRE && !I_TERM_REV_RUN;
  assign c[0] = O_SRC_SEL[0] && !I_THREE_WIRE
                && !I_TERM_FWD_RUN && !I_TERM_REV_RUN;
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    for (int k = 0; k < 3; k++)
      n[k] <= (!I_ARST_N || !c[k]) ? 0 : n[k] + 1;
  sequence s_kref;
    $past(I_ARST_N, 3) && !O_SRC_SEL[1] ##1 !O_SRC_SEL[1];
  endsequence
  sequence s_aref;
    $past(I_ARST_N, 3) && O_SRC_SEL[1] ##1 O_SRC_SEL[1];
  endsequence
  sequence s_key_ok;
    !O_SRC_SEL[0] && !$past(I_SRC_SEL_WE) && !$past(I_FACTORY_RESET);
  endsequence
  a_seq_lamp: assert property (O_SEQ_SOURCE_LAMP == O_SRC_SEL[0])
    else $error("sequence lamp differs from source");
  a_ref_lamp: assert property (O_REF_SOURCE_LAMP == O_SRC_SEL[1])
    else $error("reference lamp differs from source");
  a_reset_values: assert property (
    $rose(I_ARST_N) |-> O_SRC_SEL == rss_pkg::SRC_SEL_FACTORY && !O_RUN)
    else $error("bad values after power return");
  a_key_run: assert property (
    s_key_ok and I_KEY_RUN && !I_KEY_STOP |=> O_RUN)
    else $error("run key did not start");
  a_key_stop: assert property (s_key_ok and I_KEY_STOP |=> !O_RUN)
    else $error("stop key did not stop");
  a_keypad_freq: assert property (
    s_kref |-> O_FREQ_REF == $past(I_KEYPAD_REF))
    else $error("keypad reference not passed");
  a_analog_freq: assert property (
    s_aref |-> O_FREQ_REF == $past(I_ANALOG_REF))
    else $error("analog reference not passed");
  a_two_wire_idle: assert property (
    n[0] > DEBOUNCE_CYC + 4 |-> !O_RUN)
    else $error("running with no run contact");
  a_stop_open: assert property (n[1] > DEBOUNCE_CYC + 4 |-> !O_RUN)
    else $error("running with stop contact open");
  a_both_fault: assert property (
    n[2] > DEBOUNCE_CYC + 4 |-> O_EXT_FAULT && !O_RUN)
    else $error("both run contacts without fault");
endmodule
bind rss_top rss_top_properties #(
  .REF_W        (REF_W),
  .DEBOUNCE_CYC (DEBOUNCE_CYC)
) u_chk (.*);
`default_nettype wire

/* File: testbench/rss_contact_model.sv */
// Partner: switches and relay contacts with chatter on every change
`timescale 1ns/1ns
`default_nettype none
module rss_contact_model (
  input  wire logic       clk,   // System clock
  input  wire logic [2:0] want,  // Commanded closures
  output logic      [2:0] cont   // Contact levels, 1 = closed
);
  logic [1:0] bn [3];
  initial
  begin
    cont = 3'h0;
    bn   = '{default: 2'h0};
  end
  // Closure held as commanded, two bounces shorter than debounce
  always @(posedge clk)
    for (int k = 0; k < 3; k++)
      if (bn[k] != 2'h0)
      begin
        cont[k] <= #1 ~cont[k];
        bn[k]   <= #1 bn[k] - 2'h1;
      end
      else if (cont[k] != want[k])
      begin
        cont[k] <= #1 want[k];
        bn[k]   <= #1 2'h2;
      end
endmodule
`default_nettype wire

/* File: testbench/run_stop_sequence_select_test.sv */
// Testbench: directed scenarios for the run/stop source select block
`timescale 1ns/1ns
`default_nettype none
module run_stop_sequence_select_test;
  logic        clk = 1'h0, arst_n = 1'h0, fr = 1'h0, we = 1'h0, thr = 1'h0;
  logic        kr = 1'h0, ks = 1'h0, kd = 1'h0;
  logic [1:0]  sel = 2'h0, osel;
  logic [2:0]  want = 3'h0, cont;
  logic [11:0] kref = 12'h000, aref = 12'h000, fref;
  logic        run, dir, flt, lseq, lref;
  int          n_mismatch = 0, n_compared = 0;
  always #5 clk = ~clk;
  rss_contact_model u_sw (.clk(clk), .want(want), .cont(cont));
  rss_top #(.REF_W(12), .DEBOUNCE_CYC(4)) dut (
    .I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_FACTORY_RESET(fr),
    .I_SRC_SEL_WE(we), .I_SRC_SEL(sel), .I_THREE_WIRE(thr),
    .I_KEY_RUN(kr), .I_KEY_STOP(ks), .I_DIRECTION_KEY(kd),
    .I_TERM_FWD_RUN(cont[0]), .I_TERM_REV_RUN(cont[1]), .I_TERM_DIR(cont[2]),
    .I_KEYPAD_REF(kref), .I_ANALOG_REF(aref), .O_RUN(run), .O_DIR(dir),
    .O_EXT_FAULT(flt), .O_FREQ_REF(fref), .O_SRC_SEL(osel),
    .O_SEQ_SOURCE_LAMP(lseq), .O_REF_SOURCE_LAMP(lref));
  task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic src(logic [1:0] c);
    sel = c;
    we  = 1'h1;
    cyc(1);
    we  = 1'h0;
    cyc(2);
  endtask
  task automatic key(int w);
    {kr, ks, kd} = 3'h4 >> w;
    cyc(1);
    {kr, ks, kd} = 3'h0;
    cyc(1);
  endtask
  task automatic cl(logic [2:0] w);
    want = w;
    cyc(16);
  endtask
  task automatic pwr;
    arst_n = 1'h0;
    cyc(2);
    arst_n = 1'h1;
    cyc(20);
  endtask
  task automatic t_sources;
    chk("default src", 12'h3, {10'h0, osel});
    chk("default lamps", 12'h3, {10'h0, lref, lseq});
    for (int c = 0; c < 4; c++)
    begin
      src(c[1:0]);
      chk("seq lamp", {11'h0, c[0]}, {11'h0, lseq});
      chk("ref lamp", {11'h0, c[1]}, {11'h0, lref});
    end
    src(2'h0);
    fr = 1'h1;
    cyc(1);
    fr = 1'h0;
    cyc(2);
    chk("factory src", 12'h3, {10'h0, osel});
    $display("done sources");
  endtask
  task automatic t_keypad;
    src(2'h0);
    key(0);
    chk("key run", 12'h1, {11'h0, run});
    key(2);
    chk("key dir", 12'h1, {11'h0, dir});
    key(2);
    chk("key dir back", 12'h0, {11'h0, dir});
    key(1);
    chk("key stop", 12'h0, {11'h0, run});
    src(2'h1);
    kr = 1'h1;
    cyc(1);
    chk("key ignored", 12'h0, {11'h0, run});
    kr = 1'h0;
    cyc(1);
    $display("done keypad");
  endtask
  task automatic t_two_wire;
    src(2'h3);
    cl(3'h1);
    chk("2w fwd", 12'h2, {10'h0, run, dir});
    cl(3'h3);
    chk("2w both", 12'h1, {10'h0, run, flt});
    cl(3'h2);
    chk("2w rev", 12'h6, {9'h0, run, dir, flt});
    pwr();
    chk("2w resume", 12'h1, {11'h0, run});
    cl(3'h0);
    chk("2w idle", 12'h0, {11'h0, run});
    $display("done two wire");
  endtask
  task automatic t_three_wire;
    thr = 1'h1;
    cl(3'h2);
    cl(3'h3);
    cl(3'h2);
    chk("3w latch", 12'h1, {11'h0, run});
    cl(3'h6);
    chk("3w rev", 12'h3, {10'h0, run, dir});
    cl(3'h4);
    chk("3w stop", 12'h0, {11'h0, run});
    cl(3'h5);
    cl(3'h4);
    cl(3'h6);
    chk("3w refused", 12'h0, {11'h0, run});
    cl(3'h7);
    cl(3'h2);
    chk("3w fwd run", 12'h2, {10'h0, run, dir});
    pwr();
    chk("3w power loss", 12'h0, {11'h0, run});
    $display("done three wire");
  endtask
  task automatic t_freq;
    kref = 12'h123;
    aref = 12'hABC;
    src(2'h0);
    cyc(2);
    chk("keypad ref", kref, fref);
    src(2'h2);
    cyc(2);
    chk("analog ref", 12'hABC, fref);
    aref = 12'hFFF;
    cyc(2);
    chk("analog top", 12'hFFF, fref);
    $display("done freq");
  endtask
  task automatic summarize;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    #1;
    arst_n = 1'h1;
    cyc(3);
    t_sources();
    t_keypad();
    t_two_wire();
    t_three_wire();
    t_freq();
    summarize();
  end
  initial
  begin
    #50000;
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
